// *** ring_frame_map.vh ***
// constants for the token ring frame field block
//
// Contract
// - transmitter sends 8 to 40 bytes of idle lead-in before each frame
// - receiver accepts and repeats frames with no idle lead-in at all
// - start delimiter is one whole byte on receive; transmit aligns it too
// - length bit zero means 16-bit addresses, one means 48-bit
// - top frame control bit: zero asynchronous, one synchronous
// - format bits: management/MAC, logical link, implementer, future use
// - 80 unrestricted token, c0 restricted token, class zero code zero void
// - class zero: management or next-station; class one: beacon, claim, purge, other
// - hold one 16-bit and one 48-bit own individual address
// - individual destination compared to own address of frame length
// - group destination compared against recognised group set
// - source address length equals destination address length
// - source compared to own address ignoring top bit, sets own-source flag
// - transmit replaces source with own address, top bit zero
// - option sends source address unchanged from the stream
// - option passes only source top bit from the stream
// - receive checks minimum info length and even symbol count
// - first 4 info bytes of MAC frames compared with next MAC frame
// - check 32-bit CRC on receive, append on transmit unless passthrough
// - own frames end with reset E, A and C indicators only
// - repeated frames get E, A, C updated; further indicators pass
`ifndef RING_FRAME_MAP_VH
`define RING_FRAME_MAP_VH
`define REG_CTRL      3'h0
`define REG_SHORT     3'h1
`define REG_LONG_LO   3'h2
`define REG_LONG_HI   3'h3
`define REG_GRP_LO    3'h4
`define REG_GRP_HI    3'h5
`define REG_STATUS    3'h6
`define CTRL_SA_PASS  0
`define CTRL_MSB_PASS 1
`define CTRL_FCS_PASS 2
`define CTRL_LEAD_LSB 8
`define CTRL_LEAD_MSB 13
`define LEAD_RESET    6'h08
`define LEAD_MIN      6'h08
`define LEAD_MAX      6'h28
`define SYM_I         4'h1
`define SYM_T         4'h4
`define SYM_R         4'h5
`define SYM_S         4'h6
`define SYM_JK        8'h23
`define SYM_II        8'h11
`define SYM_TR        8'h45
`define SYM_RR        8'h55
`define FC_C          7
`define FC_L          6
`define ALEN_S_LAST   3'h1
`define ALEN_L_LAST   3'h5
`define FCS_LAST      3'h3
`define FCS_LEN       12'h004
`define INFO_MIN_BC   12'h004
`define INFO_CMP_LEN  12'h008
`define CRC_POLY      32'h04c11db7
`define CRC_INIT      32'hffffffff
`define CRC_RESIDUE   32'hc704dd7b
`define K_UTOK        4'h0
`define K_RTOK        4'h1
`define K_VOID        4'h2
`define K_MGMT        4'h3
`define K_NSA         4'h4
`define K_BEACON      4'h5
`define K_CLAIM       4'h6
`define K_PURGE       4'h7
`define K_OMAC        4'h8
`define K_LLC         4'h9
`define K_IMPL        4'ha
`define K_RESV        4'hb
`endif

// *** frame_crc32.v ***
// serial-in-byte crc32 engine, msb first
`timescale 1ns/1ps
`default_nettype none
`include "ring_frame_map.vh"
module frame_crc32 (
	input  wire        sys_clk_i,
	input  wire        resetn_i,
	input  wire        init_i,
	input  wire        en_i,
	input  wire [7:0]  data_i,
	output reg  [31:0] crc_o
);
	reg [31:0] c;
	integer    k;
	always @* begin
		c = crc_o;
		for (k = 7; k >= 0; k = k - 1) begin
			c = {c[30:0], 1'b0} ^ ((c[31] ^ data_i[k]) ? `CRC_POLY : 32'h0);
		end
	end
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			crc_o <= `CRC_INIT;
		else if (init_i)
			crc_o <= `CRC_INIT;
		else if (en_i)
			crc_o <= c;
	end
endmodule // frame_crc32
`default_nettype wire

// *** fc_decode.v ***
// frame control byte classifier
`timescale 1ns/1ps
`default_nettype none
`include "ring_frame_map.vh"
module fc_decode (
	input  wire [7:0] fc_i,
	output reg  [3:0] kind_o
);
	always @* begin
		case (fc_i[5:4])
		2'b01: kind_o = `K_LLC;
		2'b10: kind_o = `K_IMPL;
		2'b11: kind_o = `K_RESV;
		default: begin
			if (fc_i[`FC_C]) begin
				case (fc_i[3:0])
				4'h0: kind_o = fc_i[`FC_L] ? `K_RTOK : `K_UTOK;
				4'h2: kind_o = `K_BEACON;
				4'h3: kind_o = `K_CLAIM;
				4'h4: kind_o = `K_PURGE;
				default: kind_o = `K_OMAC;
				endcase
			end else begin
				case (fc_i[3:0])
				4'h0: kind_o = `K_VOID;
				4'hf: kind_o = `K_NSA;
				default: kind_o = `K_MGMT;
				endcase
			end
		end
		endcase
	end
endmodule // fc_decode
`default_nettype wire

// *** token_ring_frame_fields.v ***
// ring engine frame fields: receive parse, repeat, transmit build, registers
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ring_frame_map.vh"
module token_ring_frame_fields #(
	parameter ICNT_W = 12
) (
	input  wire        sys_clk_i,
	input  wire        resetn_i,
	input  wire [2:0]  avs_address_i,
	input  wire        avs_read_i,
	input  wire        avs_write_i,
	input  wire [31:0] avs_writedata_i,
	output reg  [31:0] avs_readdata_o,
	output reg         avs_waitrequest_o,
	input  wire [7:0]  rx_sym_i,
	input  wire [1:0]  rx_ctl_i,
	output reg  [7:0]  tx_sym_o,
	output reg  [1:0]  tx_ctl_o,
	input  wire        copy_i,
	output reg  [7:0]  rx_data_o,
	output reg         rx_data_valid_o,
	output reg         rx_done_o,
	output reg  [3:0]  rx_kind_o,
	output reg         addr_match_o,
	output reg         own_source_match_o,
	output reg         crc_ok_o,
	output reg         len_ok_o,
	output reg         repeated_info_o,
	input  wire        tx_req_i,
	input  wire [7:0]  tx_data_i,
	input  wire        tx_valid_i,
	input  wire        tx_last_i,
	output reg         tx_ready_o,
	output reg         tx_done_o,
	output reg         tx_abort_o
);
	localparam R_IDLE = 3'h0, R_FC = 3'h1, R_TOK = 3'h2, R_DA = 3'h3;
	localparam R_SA = 3'h4, R_INFO = 3'h5, R_STAT = 3'h6;
	localparam T_IDLE = 4'h0, T_PRE = 4'h1, T_SD = 4'h2, T_FC = 4'h3, T_DA = 4'h4;
	localparam T_SA = 4'h5, T_INFO = 4'h6, T_FCS = 4'h7, T_ED = 4'h8, T_FS = 4'h9;

	function addr_eq;
		input [47:0] a;
		input [47:0] b;
		input        lng;
		input        ign_msb;
		reg   [47:0] m;
		begin
			m = lng ? 48'hffffffffffff : 48'h00000000ffff;
			if (ign_msb && lng)
				m[47] = 1'b0;
			if (ign_msb && !lng)
				m[15] = 1'b0;
			addr_eq = ((a ^ b) & m) == 48'h0;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// registers over avalon
	reg [2:0]  ctrl_r;
	reg [5:0]  lead_r;
	reg [15:0] own_short_r;
	reg [47:0] own_long_r;
	reg [47:0] grp_r;
	reg [31:0] rdata_nxt;
	wire       req = avs_read_i | avs_write_i;
	wire       wr_go = avs_write_i & ~avs_waitrequest_o;
	wire [5:0] lead_w = avs_writedata_i[`CTRL_LEAD_MSB:`CTRL_LEAD_LSB];
	reg [3:0]  tx_state_r;

	always @* begin
		case (avs_address_i)
		`REG_CTRL: rdata_nxt = {18'h0, lead_r, 5'h0, ctrl_r};
		`REG_SHORT: rdata_nxt = {16'h0, own_short_r};
		`REG_LONG_LO: rdata_nxt = own_long_r[31:0];
		`REG_LONG_HI: rdata_nxt = {16'h0, own_long_r[47:32]};
		`REG_GRP_LO: rdata_nxt = grp_r[31:0];
		`REG_GRP_HI: rdata_nxt = {16'h0, grp_r[47:32]};
		`REG_STATUS: rdata_nxt = {21'h0, tx_abort_o, tx_state_r != T_IDLE,
			repeated_info_o, len_ok_o, crc_ok_o, own_source_match_o,
			addr_match_o, rx_kind_o};
		default: rdata_nxt = 32'h0;
		endcase
	end

	// one wait state: answer is held low for exactly one cycle
	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0;
			ctrl_r <= 3'h0;
			lead_r <= `LEAD_RESET;
			own_short_r <= 16'h0;
			own_long_r <= 48'h0;
			grp_r <= 48'h0;
		end else begin
			avs_waitrequest_o <= ~(req & avs_waitrequest_o);
			if (req & avs_waitrequest_o)
				avs_readdata_o <= rdata_nxt;
			if (wr_go) begin
				case (avs_address_i)
				`REG_CTRL: begin
					ctrl_r <= avs_writedata_i[2:0];
					if (lead_w < `LEAD_MIN)
						lead_r <= `LEAD_MIN;
					else if (lead_w > `LEAD_MAX)
						lead_r <= `LEAD_MAX;
					else
						lead_r <= lead_w;
				end
				`REG_SHORT: own_short_r <= avs_writedata_i[15:0];
				`REG_LONG_LO: own_long_r[31:0] <= avs_writedata_i;
				`REG_LONG_HI: own_long_r[47:32] <= avs_writedata_i[15:0];
				`REG_GRP_LO: grp_r[31:0] <= avs_writedata_i;
				`REG_GRP_HI: grp_r[47:32] <= avs_writedata_i[15:0];
				default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive: pins pass two flops before use
	reg [9:0]        rx_s1_r;
	reg [9:0]        rx_s2_r;
	reg [2:0]        rx_state_r;
	reg [2:0]        rcnt_r;
	reg [7:0]        fc_r;
	reg [3:0]        kind_r;
	reg [47:0]       da_r;
	reg [47:0]       sa_r;
	reg [ICNT_W-1:0] icnt_r;
	reg [31:0]       cur_info_r;
	reg [31:0]       prev_info_r;
	reg              prev_mac_r;
	reg              hit_r;
	wire [3:0]       fc_kind;
	wire [31:0]      rx_crc;
	wire [7:0]       rd = rx_s2_r[7:0];
	wire [1:0]       rc = rx_s2_r[9:8];
	wire rx_jk = (rc == 2'b11) && (rd == `SYM_JK);
	wire rx_t_hi = rc[1] && (rd[7:4] == `SYM_T);
	wire rx_t_lo = (rc == 2'b01) && (rd[3:0] == `SYM_T);
	wire rx_lng = fc_r[`FC_L];
	wire [2:0] alast = rx_lng ? `ALEN_L_LAST : `ALEN_S_LAST;
	wire [47:0] own_sel = rx_lng ? own_long_r : {32'h0, own_short_r};
	wire da_grp = rx_lng ? da_r[47] : da_r[15];
	wire da_hit = da_grp ? (addr_eq(da_r, 48'hffffffffffff, rx_lng, 1'b0) |
		addr_eq(da_r, grp_r, rx_lng, 1'b0)) :
		addr_eq(da_r, own_sel, rx_lng, 1'b0);
	wire sa_hit = addr_eq(sa_r, own_sel, rx_lng, 1'b1);
	wire crc_good = rx_crc == `CRC_RESIDUE;
	wire is_bc = (kind_r == `K_BEACON) || (kind_r == `K_CLAIM);
	wire [ICNT_W-1:0] need = is_bc ? `FCS_LEN + `INFO_MIN_BC : `FCS_LEN;
	wire len_good = rx_t_hi && (icnt_r >= need);
	wire rx_err = ~crc_good | ~len_good;
	wire is_mac = (kind_r >= `K_BEACON) && (kind_r <= `K_OMAC);
	wire info_full = icnt_r >= `INFO_CMP_LEN;
	wire rx_end = (rx_state_r == R_INFO) && (rx_t_hi | rx_t_lo);
	wire rx_dat = (rc == 2'b00);
	wire crc_en = rx_dat && (rx_state_r == R_FC || rx_state_r == R_DA ||
		rx_state_r == R_SA || rx_state_r == R_INFO);

	fc_decode u_fc_decode (
		.fc_i   (rd),
		.kind_o (fc_kind)
	);

	frame_crc32 u_rx_crc (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.init_i    (rx_jk),
		.en_i      (crc_en),
		.data_i    (rd),
		.crc_o     (rx_crc)
	);

	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_s1_r <= 10'h0;
			rx_s2_r <= 10'h0;
			rx_state_r <= R_IDLE;
			rcnt_r <= 3'h0;
			fc_r <= 8'h0;
			kind_r <= `K_VOID;
			da_r <= 48'h0;
			sa_r <= 48'h0;
			icnt_r <= {ICNT_W{1'b0}};
			cur_info_r <= 32'h0;
			prev_info_r <= 32'h0;
			prev_mac_r <= 1'b0;
			hit_r <= 1'b0;
			rx_data_o <= 8'h0;
			rx_data_valid_o <= 1'b0;
			rx_done_o <= 1'b0;
			rx_kind_o <= `K_VOID;
			addr_match_o <= 1'b0;
			own_source_match_o <= 1'b0;
			crc_ok_o <= 1'b0;
			len_ok_o <= 1'b0;
			repeated_info_o <= 1'b0;
		end else begin
			rx_s1_r <= {rx_ctl_i, rx_sym_i};
			rx_s2_r <= rx_s1_r;
			rx_data_o <= rd;
			rx_data_valid_o <= crc_en;
			rx_done_o <= 1'b0;
			if (rx_jk) begin
				rx_state_r <= R_FC;
			end else begin
				case (rx_state_r)
				R_FC: begin
					fc_r <= rd;
					kind_r <= fc_kind;
					rcnt_r <= 3'h0;
					if (!rx_dat)
						rx_state_r <= R_IDLE;
					else if (fc_kind == `K_UTOK || fc_kind == `K_RTOK)
						rx_state_r <= R_TOK;
					else
						rx_state_r <= R_DA;
				end
				R_TOK: begin
					rx_state_r <= R_IDLE;
					if (rx_t_hi) begin
						rx_done_o <= 1'b1;
						rx_kind_o <= kind_r;
						addr_match_o <= 1'b0;
						own_source_match_o <= 1'b0;
						crc_ok_o <= 1'b1;
						len_ok_o <= 1'b1;
						repeated_info_o <= 1'b0;
					end
				end
				R_DA, R_SA: begin
					if (!rx_dat) begin
						rx_state_r <= R_IDLE;
					end else begin
						rcnt_r <= rcnt_r + 3'h1;
						if (rx_state_r == R_DA)
							da_r <= {da_r[39:0], rd};
						else
							sa_r <= {sa_r[39:0], rd};
						if (rcnt_r == alast) begin
							rcnt_r <= 3'h0;
							icnt_r <= {ICNT_W{1'b0}};
							rx_state_r <= (rx_state_r == R_DA) ? R_SA : R_INFO;
						end
					end
				end
				R_INFO: begin
					if (rx_dat) begin
						if (icnt_r != {ICNT_W{1'b1}})
							icnt_r <= icnt_r + {{(ICNT_W-1){1'b0}}, 1'b1};
						if (icnt_r < `FCS_LEN)
							cur_info_r <= {cur_info_r[23:0], rd};
					end else if (rx_end) begin
						rx_state_r <= R_STAT;
						hit_r <= da_hit;
						rx_done_o <= 1'b1;
						rx_kind_o <= kind_r;
						addr_match_o <= da_hit;
						own_source_match_o <= sa_hit;
						crc_ok_o <= crc_good;
						len_ok_o <= len_good;
						repeated_info_o <= is_mac && info_full && prev_mac_r &&
							(cur_info_r == prev_info_r);
						if (is_mac) begin
							prev_info_r <= cur_info_r;
							prev_mac_r <= info_full;
						end
						rcnt_r <= 3'h0;
					end else begin
						rx_state_r <= R_IDLE;
					end
				end
				R_STAT: begin
					rcnt_r <= 3'h1;
					if (rc != 2'b11)
						rx_state_r <= R_IDLE;
				end
				default: rx_state_r <= R_IDLE;
				endcase
			end
		end
	end

	// repeat path with status indicator update
	reg [7:0] rep_d;
	always @* begin
		rep_d = rd;
		if (rx_end && rx_t_hi && rd[3:0] == `SYM_R && rx_err)
			rep_d[3:0] = `SYM_S;
		if (rx_state_r == R_STAT && rcnt_r == 3'h0 && rc == 2'b11 && !rx_jk) begin
			if (hit_r)
				rep_d[7:4] = `SYM_S;
			if (hit_r && copy_i)
				rep_d[3:0] = `SYM_S;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit
	reg [3:0]  tx_nxt;
	reg [5:0]  pcnt_r;
	reg [2:0]  tcnt_r;
	reg        tx_lng_r;
	reg [7:0]  tx_b;
	reg [9:0]  tx_out;
	wire [31:0] tx_crc;
	wire       take = tx_valid_i & tx_ready_o;
	wire       fcs_pass = ctrl_r[`CTRL_FCS_PASS];
	wire [2:0] tlast = tx_lng_r ? `ALEN_L_LAST : `ALEN_S_LAST;
	wire [47:0] own_tx = tx_lng_r ? own_long_r : {own_short_r, 32'h0};
	wire [47:0] own_sh = own_tx << {tcnt_r, 3'b000};
	wire [31:0] crc_sh = tx_crc << {tcnt_r[1:0], 3'b000};
	wire       in_data = (tx_state_r == T_FC) || (tx_state_r == T_DA) ||
		(tx_state_r == T_SA) || (tx_state_r == T_INFO);

	frame_crc32 u_tx_crc (
		.sys_clk_i (sys_clk_i),
		.resetn_i  (resetn_i),
		.init_i    (tx_state_r == T_SD),
		.en_i      (take),
		.data_i    (tx_b),
		.crc_o     (tx_crc)
	);

	always @* begin
		tx_b = tx_data_i;
		if (tx_state_r == T_SA && !ctrl_r[`CTRL_SA_PASS]) begin
			tx_b = own_sh[47:40];
			if (tcnt_r == 3'h0)
				tx_b[7] = ctrl_r[`CTRL_MSB_PASS] & tx_data_i[7];
		end
	end

	always @* begin
		tx_nxt = tx_state_r;
		tx_out = {2'b00, tx_b};
		case (tx_state_r)
		T_IDLE: begin
			tx_out = {rc, rep_d};
			if (tx_req_i)
				tx_nxt = T_PRE;
		end
		T_PRE: begin
			tx_out = {2'b11, `SYM_II};
			if (pcnt_r == lead_r - 6'h1)
				tx_nxt = T_SD;
		end
		T_SD: begin
			tx_out = {2'b11, `SYM_JK};
			tx_nxt = T_FC;
		end
		T_FC, T_DA, T_SA, T_INFO: begin
			if (!tx_valid_i) begin
				tx_out = {2'b11, `SYM_II};
				tx_nxt = T_IDLE;
			end else if (tx_state_r == T_FC) begin
				tx_nxt = T_DA;
			end else if (tx_state_r != T_INFO && tcnt_r != tlast) begin
				tx_nxt = tx_state_r;
			end else if (tx_state_r == T_DA) begin
				tx_nxt = T_SA;
			end else if (tx_last_i) begin
				tx_nxt = fcs_pass ? T_ED : T_FCS;
			end else begin
				tx_nxt = T_INFO;
			end
		end
		T_FCS: begin
			tx_out = {2'b00, ~crc_sh[31:24]};
			if (tcnt_r == `FCS_LAST)
				tx_nxt = T_ED;
		end
		T_ED: begin
			tx_out = {2'b11, `SYM_TR};
			tx_nxt = T_FS;
		end
		T_FS: begin
			tx_out = {2'b11, `SYM_RR};
			tx_nxt = T_IDLE;
		end
		default: tx_nxt = T_IDLE;
		endcase
	end

	always @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_state_r <= T_IDLE;
			pcnt_r <= 6'h0;
			tcnt_r <= 3'h0;
			tx_lng_r <= 1'b0;
			tx_sym_o <= `SYM_II;
			tx_ctl_o <= 2'b11;
			tx_ready_o <= 1'b0;
			tx_done_o <= 1'b0;
			tx_abort_o <= 1'b0;
		end else begin
			tx_state_r <= tx_nxt;
			tx_sym_o <= tx_out[7:0];
			tx_ctl_o <= tx_out[9:8];
			tx_ready_o <= (tx_nxt == T_FC) || (tx_nxt == T_DA) ||
				(tx_nxt == T_SA) || (tx_nxt == T_INFO);
			tx_done_o <= (tx_state_r == T_FS);
			pcnt_r <= (tx_state_r == T_PRE) ? pcnt_r + 6'h1 : 6'h0;
			if (tx_state_r == T_IDLE && tx_req_i)
				tx_abort_o <= 1'b0;
			if (in_data && !tx_valid_i)
				tx_abort_o <= 1'b1;
			if (tx_state_r == T_FC && take)
				tx_lng_r <= tx_data_i[`FC_L];
			if (tx_nxt != tx_state_r)
				tcnt_r <= 3'h0;
			else
				tcnt_r <= tcnt_r + 3'h1;
		end
	end
endmodule // token_ring_frame_fields
`default_nettype wire

// *** token_ring_frame_fields_monitor.sv ***
// port-level assertions for the frame field block
`timescale 1ns/1ps
`default_nettype none
module token_ring_frame_fields_monitor (
	input wire logic       sys_clk_i,
	input wire logic       resetn_i,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input wire logic [7:0] tx_sym_o,
	input wire logic [1:0] tx_ctl_o,
	input wire logic       tx_req_i,
	input wire logic       tx_valid_i,
	input wire logic       tx_ready_o,
	input wire logic       tx_done_o,
	input wire logic       tx_abort_o,
	input wire logic       rx_done_o,
	input wire logic [3:0] rx_kind_o,
	input wire logic       crc_ok_o,
	input wire logic       len_ok_o,
	input wire logic       addr_match_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////
	sequence s_lead;
		(tx_sym_o == 8'h11 && tx_ctl_o == 2'b11) [*7];
	endsequence
	sequence s_delim;
		tx_sym_o == 8'h23 && tx_ctl_o == 2'b11;
	endsequence
	// pins are registered, so the lead-in run is checked one cycle late
	a_lead_min_idle: assert property ($rose(tx_req_i) |=> ##2 s_lead)
		else $error("lead-in shorter than minimum");
	a_lead_max_delim: assert property ($rose(tx_req_i) |-> ##[9:44] s_delim)
		else $error("start delimiter late or missing");
	a_bus_answer_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer not one cycle after request");
	a_bus_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low longer than one cycle");
	a_rx_done_pulse: assert property (rx_done_o |=> !rx_done_o)
		else $error("receive done longer than one cycle");
	a_tx_done_pulse: assert property ($rose(tx_done_o) |=> $fell(tx_done_o))
		else $error("transmit done longer than one cycle");
	a_token_flag_set: assert property (rx_done_o && rx_kind_o <= 4'h1 |-> crc_ok_o && len_ok_o && !addr_match_o)
		else $error("token reported with wrong flags");
	a_abort_underrun: assert property (tx_ready_o && !tx_valid_i |-> ##[1:2] tx_abort_o)
		else $error("underrun without abort");
endmodule // token_ring_frame_fields_monitor
`default_nettype wire

// *** phy_symbol_model.sv ***
// physical-layer symbol side: sends receive pairs, captures transmit pairs
`timescale 1ns/1ps
`default_nettype none
module phy_symbol_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] tx_sym_i,
	input  wire logic [1:0] tx_ctl_i,
	output var  logic [7:0] sym_o,
	output var  logic [1:0] ctl_o
);
	logic [9:0] cap[$];
	logic       on_r;
	int         run_r;
	int         lead_r;
	initial begin
		sym_o = 8'h11;
		ctl_o = 2'b11;
		on_r = 1'b0;
		run_r = 0;
		lead_r = 0;
	end
	// whole pairs only, so a delimiter never straddles two transfers
	task automatic send(input logic [7:0] s, input logic [1:0] c);
		@(posedge sys_clk_i);
		sym_o <= s;
		ctl_o <= c;
	endtask
	////////////////////////////////////////////////////////////////
	// idle run length before the delimiter gives the lead-in
	always @(posedge sys_clk_i) begin
		run_r <= ({tx_ctl_i, tx_sym_i} == 10'h311) ? run_r + 1 : 0;
		if ({tx_ctl_i, tx_sym_i} == 10'h323) begin
			lead_r <= run_r;
			cap.delete();
			on_r <= 1'b1;
		end else if (on_r) begin
			cap.push_back({tx_ctl_i, tx_sym_i});
			if (cap.size() > 1 && cap[cap.size()-2][9:4] == 6'h34) on_r <= 1'b0;
		end
	end
endmodule // phy_symbol_model
`default_nettype wire

// *** token_ring_frame_fields_tb.sv ***
// self-checking bench for the frame field block
`timescale 1ns/1ps
`default_nettype none
module token_ring_frame_fields_tb;
	logic        sys_clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
	logic [2:0]  avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	logic [7:0]  rx_sym_i, tx_sym_o, rx_data_o, tx_data_i;
	logic [1:0]  rx_ctl_i, tx_ctl_o;
	logic [3:0]  rx_kind_o;
	logic        copy_i, rx_data_valid_o, rx_done_o, addr_match_o, own_source_match_o, crc_ok_o, len_ok_o;
	logic        repeated_info_o, tx_req_i, tx_valid_i, tx_last_i, tx_ready_o, tx_done_o, tx_abort_o;
	int          errors, checks;
	logic [15:0] rsum = 16'h0, esum = 16'h0;
	logic [7:0]  ctl_t[12] = '{8'h00, 8'h41, 8'h0e, 8'h0f, 8'h82, 8'hc3, 8'h84, 8'h81, 8'h8f, 8'h50, 8'h20, 8'h30};
	logic [3:0]  kind_t[12] = '{4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h9, 4'ha, 4'hb};
	logic [31:0] cv[4] = '{32'h00003f00, 32'h00000802, 32'h00000801, 32'h00000800};
	logic [47:0] sv[4] = '{48'h1a2b3c4d5e6f, 48'h9a2b3c4d5e6f, 48'hffffffffffff, 48'h1234};
	token_ring_frame_fields token_ring_frame_fields_inst (.*);
	phy_symbol_model phy_symbol_model_inst (.sys_clk_i(sys_clk_i), .tx_sym_i(tx_sym_o), .tx_ctl_i(tx_ctl_o),
		.sym_o(rx_sym_i), .ctl_o(rx_ctl_i));
	always #50 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (rx_data_valid_o === 1'b1) rsum <= rsum + 16'(rx_data_o);
	////////////////////////////////////////////////////////////////
	task automatic cmp(input string n, input logic [47:0] e, input logic [47:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
	endtask
	task automatic wait_hi(input logic tx);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while ((tx ? tx_done_o : rx_done_o) !== 1'b1 && n < 100);
		if (n >= 100) cmp("done wait", 48'h1, 48'h0);
	endtask
	// msb-first reference, sent inverted
	function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
		logic [31:0] c;
		c = 32'hffffffff;
		foreach (b[i]) for (int k = 7; k >= 0; k--) c = (c << 1) ^ ((c[31] ^ b[i][k]) ? 32'h04c11db7 : 32'h0);
		return ~c;
	endfunction
	////////////////////////////////////////////////////////////////
	// no idle pairs sent before the delimiter: the idle pair that ends the previous frame is held until it
	task automatic rx_frame(input logic [7:0] fcb, input logic [47:0] dst, src, input logic [31:0] info,
		input int n, input logic bad);
		logic [7:0]  b[$];
		logic [31:0] f;
		int          w;
		w = fcb[6] ? 6 : 2;
		b = {fcb};
		if (!(fcb[7] && fcb[5:0] == 6'h00)) begin
			for (int i = w - 1; i >= 0; i--) b.push_back(dst[8*i+:8]);
			for (int i = w - 1; i >= 0; i--) b.push_back(src[8*i+:8]);
			for (int i = 0; i < n; i++) b.push_back(info[8*(3-i)+:8]);
			f = crc_of(b) ^ {31'h0, bad};
			for (int i = 3; i >= 0; i--) b.push_back(f[8*i+:8]);
		end
		foreach (b[i]) esum += 16'(b[i]);
		phy_symbol_model_inst.send(8'h23, 2'b11);
		foreach (b[i]) phy_symbol_model_inst.send(b[i], 2'b00);
		if (b.size() == 1) phy_symbol_model_inst.send(8'h44, 2'b11);
		else begin
			phy_symbol_model_inst.send(8'h45, 2'b11);
			phy_symbol_model_inst.send(8'h55, 2'b11);
		end
		phy_symbol_model_inst.send(8'h11, 2'b11);
		wait_hi(1'b0);
		repeat (4) @(posedge sys_clk_i);
		cmp("rx data", 48'(esum), 48'(rsum));
	endtask
	// receive side carries stray data so the idle run on the pins is the lead-in alone
	task automatic tx_frame(input logic [7:0] fcb, input logic [47:0] src, input int gap, input int lead);
		logic [7:0]  s[$];
		logic [7:0]  e[$];
		logic [31:0] f;
		int          w, i, n;
		w = fcb[6] ? 6 : 2;
		s = {fcb};
		for (i = w - 1; i >= 0; i--) s.push_back(8'(i + 12));
		e = s;
		for (i = w - 1; i >= 0; i--) s.push_back(8'hff);
		for (i = w - 1; i >= 0; i--) e.push_back(src[8*i+:8]);
		for (i = 0; i < 4; i++) begin
			s.push_back(8'(i + 160));
			e.push_back(8'(i + 160));
		end
		f = crc_of(e);
		for (i = 3; i >= 0; i--) e.push_back(f[8*i+:8]);
		phy_symbol_model_inst.send(8'h00, 2'b00);
		repeat (2) @(posedge sys_clk_i);
		tx_req_i <= 1'b1;
		tx_valid_i <= 1'b1;
		tx_data_i <= s[0];
		i = 0;
		n = 0;
		while (i < s.size() && n < 200) begin
			@(posedge sys_clk_i);
			n++;
			tx_req_i <= 1'b0;
			if (tx_ready_o === 1'b1) begin
				i++;
				tx_data_i <= (i < s.size()) ? s[i] : 8'h00;
				tx_last_i <= (i == s.size() - 1);
				tx_valid_i <= (i < s.size() && i != gap);
				if (i == gap) break;
			end
		end
		if (n >= 200) errors++;
		if (gap < s.size()) begin
			repeat (3) @(posedge sys_clk_i);
			cmp("abort", 48'h1, {47'h0, tx_abort_o});
		end else begin
			wait_hi(1'b1);
			repeat (4) @(posedge sys_clk_i);
			cmp("lead", 48'(lead), 48'(phy_symbol_model_inst.lead_r));
			cmp("tx length", 48'(e.size() + 2), 48'(phy_symbol_model_inst.cap.size()));
			foreach (e[k]) cmp("tx pair", {40'h0, e[k]}, 48'(phy_symbol_model_inst.cap[k]));
			cmp("tx end", 48'({10'h345, 10'h355}), {phy_symbol_model_inst.cap[e.size()], phy_symbol_model_inst.cap[e.size()+1]});
		end
		phy_symbol_model_inst.send(8'h11, 2'b11);
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#2000000;
		errors++;
		final_report();
	end
	initial begin
		{sys_clk_i, resetn_i, avs_read_i, avs_write_i, copy_i, tx_req_i, tx_valid_i, tx_last_i} = 8'h00;
		avs_address_i = 3'h0;
		avs_writedata_i = 32'h0;
		tx_data_i = 8'h00;
		repeat (8) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		bus(1'b0, 3'h0, 32'h0, q);
		cmp("ctrl reset", 48'h800, {16'h0, q});
		bus(1'b1, 3'h1, 32'h1234, q);
		bus(1'b1, 3'h2, 32'h3c4d5e6f, q);
		bus(1'b1, 3'h3, 32'h1a2b, q);
		bus(1'b0, 3'h3, 32'h0, q);
		cmp("long high", 48'h1a2b, {16'h0, q});
		bus(1'b0, 3'h1, 32'h0, q);
		cmp("short", 48'h1234, {16'h0, q});
		bus(1'b1, 3'h7, 32'hffffffff, q);
		bus(1'b0, 3'h7, 32'h0, q);
		cmp("unmapped", 48'h0, {16'h0, q});
		rx_frame(8'h80, 48'h0, 48'h0, 32'h0, 0, 1'b0);
		cmp("token", {43'h0, 5'b00110}, {43'h0, addr_match_o, own_source_match_o, crc_ok_o, len_ok_o, repeated_info_o});
		cmp("token kind", 48'h0, {44'h0, rx_kind_o});
		rx_frame(8'hc0, 48'h0, 48'h0, 32'h0, 0, 1'b0);
		cmp("rtoken kind", 48'h1, {44'h0, rx_kind_o});
		for (int k = 0; k < 12; k++) begin
			rx_frame(ctl_t[k], ctl_t[k][6] ? 48'h1a2b3c4d5e6f : 48'h1234,
				ctl_t[k][6] ? 48'h9a2b3c4d5e6f : 48'h9234, {8'(k), 24'h0}, 4, 1'b0);
			cmp("rx flags", {39'h0, kind_t[k], 5'b11110}, {39'h0, rx_kind_o, addr_match_o, own_source_match_o,
				crc_ok_o, len_ok_o, repeated_info_o});
		end
		rx_frame(8'h50, 48'hffffffffffff, 48'haa00, 32'h0, 0, 1'b0);
		cmp("group", 48'h16, {43'h0, addr_match_o, own_source_match_o, crc_ok_o, len_ok_o, repeated_info_o});
		rx_frame(8'h10, 48'h1235, 48'h1234, 32'h0, 0, 1'b0);
		cmp("miss", 48'h1, {46'h0, addr_match_o, own_source_match_o});
		rx_frame(8'h10, 48'h1234, 48'h0, 32'h0, 0, 1'b1);
		cmp("crc bad", 48'h0, {47'h0, crc_ok_o});
		cmp("error pair", 48'h346, 48'(phy_symbol_model_inst.cap[phy_symbol_model_inst.cap.size()-2]));
		rx_frame(8'h82, 48'hffff, 48'h0, 32'h0, 2, 1'b0);
		cmp("short info", 48'h0, {47'h0, len_ok_o});
		copy_i <= 1'b1;
		rx_frame(8'h81, 48'h1234, 48'h0, 32'h55aa33cc, 4, 1'b0);
		cmp("copied pair", 48'h366, 48'(phy_symbol_model_inst.cap[phy_symbol_model_inst.cap.size()-1]));
		rx_frame(8'h85, 48'h1234, 48'h0, 32'h55aa33cc, 4, 1'b0);
		cmp("same info", 48'h1, {47'h0, repeated_info_o});
		rx_frame(8'h84, 48'h1234, 48'h0, 32'h55aa33cd, 4, 1'b0);
		cmp("new info", 48'h0, {47'h0, repeated_info_o});
		bus(1'b0, 3'h6, 32'h0, q);
		cmp("status", 48'h0d7, {39'h0, q[8:0]});
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, 3'h0, cv[m], q);
			tx_frame(m == 3 ? 8'h10 : 8'h50, sv[m], 99, m == 0 ? 40 : 8);
		end
		tx_frame(8'h10, 48'h1234, 3, 8);
		final_report();
	end
endmodule // token_ring_frame_fields_tb
bind token_ring_frame_fields token_ring_frame_fields_monitor token_ring_frame_fields_monitor_inst (.*);
`default_nettype wire
